// File: core/rcg_reference_clock.v
// Reference clock generator: source mux, fractional divider, oscillator control bits.
// Assumes all clock sources arrive as sampled levels; all nine are synchronised here.
//
// Our own choices: the register addresses and the address-and-strobe port.
`include "rcg_map.vh"
module rcg_reference_clock #(
  parameter DIV_W  = 15,
  parameter FRAC_W = 9
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Register port
  input  wire [3:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regRdData,
  // Clock sources, sampled as levels
  input  wire        systemClock,
  input  wire        periphBusClock,
  input  wire        primaryOsc,
  input  wire        fastRcOsc,
  input  wire        lowPowerRcOsc,
  input  wire        secOsc,
  input  wire        usbPll,
  input  wire        sysPll,
  input  wire        refClkInPin,
  // Power state
  input  wire        idleMode,
  input  wire        sleepMode,
  // Oscillator switch done input and control outputs
  input  wire        oscSwitchDone,
  output reg         usbFrcSelect,
  output reg         secOscEnable,
  output reg         oscSwitchReq,
  output reg  [2:0]  newOscSelect,
  output reg  [5:0]  frcTune,
  // Reference output pin
  output reg         refClkOutPin,
  output reg         refClkOutEn_n
);

  // Registers.
  reg [DIV_W-1:0]  divInt;
  reg [FRAC_W-1:0] divFrac;
  reg [DIV_W-1:0]  divIntAct;
  reg [FRAC_W-1:0] divFracAct;
  reg [3:0]        srcSel;
  reg              modOn;
  reg              stopIdle;
  reg              outEn;
  reg              runSleep;
  reg              divSwitch;
  reg              reqActive;
  reg [3:0]        oscCnt;

  // Three-stage synchronisers for all nine sources; a change counts when stages agree.
  reg [8:0] srcS1;
  reg [8:0] srcS2;
  reg [8:0] srcS3;
  reg [8:0] srcLvl;
  wire [8:0] srcRaw = {refClkInPin, sysPll, usbPll, secOsc, lowPowerRcOsc, fastRcOsc,
                       primaryOsc, periphBusClock, systemClock};
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : gSync
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          srcS1[g]  <= 1'b0;
          srcS2[g]  <= 1'b0;
          srcS3[g]  <= 1'b0;
          srcLvl[g] <= 1'b0;
        end else begin
          srcS1[g] <= srcRaw[g];
          srcS2[g] <= srcS1[g];
          srcS3[g] <= srcS2[g];
          if (srcS2[g] == srcS3[g]) begin
            srcLvl[g] <= srcS3[g];
          end
        end
      end
    end
  endgenerate

  // Source mux; reserved codes give a quiet source.
  function srcPick;
    input [3:0] sel;
    input [8:0] lvl;
    begin
      if (sel <= `RCG_SEL_EXTIN) begin // R5
        srcPick = lvl[sel];
      end else begin
        srcPick = 1'b0;
      end
    end
  endfunction

  wire srcBit = srcPick(srcSel, srcLvl);
  reg  srcPrev;
  wire srcEdge = srcBit & ~srcPrev;

  // Sleep stops the output unless allowed; the clock-derived sources always stop.
  wire sleepStop = sleepMode & (~runSleep | (srcSel == `RCG_SEL_SYSTEM_CLOCK) |
                   (srcSel == `RCG_SEL_PERIPH_BUS_CLOCK)); // R11
  wire running = modOn & ~(stopIdle & idleMode) & ~sleepStop; // R8 R9

  // Fractional divider: half period is divIntAct + frac/512 source edges.
  // Accumulating the fraction dithers the half period rather than adding jitter-free delay.
  reg [DIV_W-1:0]  halfCnt;
  reg [FRAC_W-1:0] fracAcc;
  reg              outClk;
  wire [FRAC_W:0]  fracSum = {1'b0, fracAcc} + {1'b0, divFracAct};
  wire [DIV_W:0]   halfLen = {1'b0, divIntAct} + {{DIV_W{1'b0}}, fracSum[FRAC_W]};
  wire             halfEnd = srcEdge && ({1'b0, halfCnt} + 16'h0001 >= halfLen);
  wire             passThru = (divIntAct == {DIV_W{1'b0}}); // R18
  // The high half end is the output clock boundary where a new divider may load.
  wire             boundary = passThru ? 1'b1 : (halfEnd & outClk);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      srcPrev    <= 1'b0;
      halfCnt    <= {DIV_W{1'b0}};
      fracAcc    <= {FRAC_W{1'b0}};
      outClk     <= 1'b0;
      divIntAct  <= {DIV_W{1'b0}};
      divFracAct <= {FRAC_W{1'b0}};
      divSwitch  <= 1'b0;
      reqActive  <= 1'b0;
    end else begin
      srcPrev   <= srcBit;
      reqActive <= running; // R15
      if (!running) begin
        halfCnt <= {DIV_W{1'b0}};
        fracAcc <= {FRAC_W{1'b0}};
        outClk  <= 1'b0;
      end else if (passThru) begin
        outClk <= srcBit; // R18
      end else if (srcEdge) begin
        if (halfEnd) begin
          halfCnt <= {DIV_W{1'b0}};
          fracAcc <= fracSum[FRAC_W-1:0]; // R7
          outClk  <= ~outClk; // R18
        end else begin
          halfCnt <= halfCnt + {{(DIV_W-1){1'b0}}, 1'b1}; // R6
        end
      end
      // Divider values load directly while off, else only on a switch, at a boundary or while not running.
      if (!modOn) begin
        divIntAct  <= divInt; // R13 R14
        divFracAct <= divFrac;
      end
      if (regWrite && regAddr == `RCG_ADDR_REF_CTRL && regWrData[`RCG_DIVSW_BIT]) begin
        divSwitch <= 1'b1; // R12
      end else if (divSwitch && (!running || boundary)) begin
        divIntAct  <= divInt; // R19
        divFracAct <= divFrac;
        divSwitch  <= 1'b0; // R12
      end
    end
  end

  // Register writes and oscillator switch.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      usbFrcSelect <= 1'b0;
      secOscEnable <= 1'b0;
      oscSwitchReq <= 1'b0;
      newOscSelect <= `RCG_NOSC_RESET;
      frcTune      <= 6'h00;
      divInt       <= {DIV_W{1'b0}};
      divFrac      <= {FRAC_W{1'b0}};
      srcSel       <= 4'h0;
      modOn        <= 1'b0;
      stopIdle     <= 1'b0;
      outEn        <= 1'b0;
      runSleep     <= 1'b0;
      oscCnt       <= 4'h0;
    end else begin
      if (oscSwitchReq) begin
        oscCnt <= oscCnt + 4'h1;
      end
      // Completion comes from the clock switcher or a timeout so the bit never sticks.
      if (oscSwitchReq && (oscSwitchDone || oscCnt == `RCG_OSC_SWITCH_CYC)) begin
        oscSwitchReq <= 1'b0; // R3
        oscCnt       <= 4'h0;
      end
      if (regWrite) begin
        case (regAddr)
          `RCG_ADDR_OSC_CTRL: begin
            usbFrcSelect <= regWrData[`RCG_USB_FRC_BIT]; // R1
            secOscEnable <= regWrData[`RCG_SOSC_EN_BIT]; // R2
            newOscSelect <= regWrData[`RCG_NOSC_MSB:`RCG_NOSC_LSB]; // R20
            if (regWrData[`RCG_OSC_SWITCH_BIT]) begin
              oscSwitchReq <= 1'b1; // R3
              oscCnt       <= 4'h0;
            end
          end
          `RCG_ADDR_FRC_TUNE: begin
            frcTune <= regWrData[`RCG_TUNE_MSB:0]; // R4
          end
          `RCG_ADDR_REF_CTRL: begin
            divInt   <= regWrData[`RCG_DIV_MSB:`RCG_DIV_LSB]; // R6
            modOn    <= regWrData[`RCG_ON_BIT]; // R8
            stopIdle <= regWrData[`RCG_IDLE_BIT]; // R9
            outEn    <= regWrData[`RCG_OUT_EN_BIT]; // R10
            runSleep <= regWrData[`RCG_SLEEP_BIT]; // R11
            srcSel   <= regWrData[`RCG_SEL_MSB:0]; // R5
          end
          `RCG_ADDR_REF_TRIM: begin
            divFrac <= regWrData[`RCG_FRAC_MSB:`RCG_FRAC_LSB]; // R7
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read data one cycle after the strobe; unused bits are zero.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 32'h00000000;
    end else begin
      regRdData <= 32'h00000000; // R17
      if (regRead) begin
        case (regAddr)
          `RCG_ADDR_OSC_CTRL: begin
            regRdData <= {21'h000000, newOscSelect, 5'h00, usbFrcSelect, secOscEnable,
                          oscSwitchReq}; // R3
          end
          `RCG_ADDR_FRC_TUNE: begin
            regRdData <= {26'h0000000, frcTune}; // R17
          end
          `RCG_ADDR_REF_CTRL: begin
            regRdData <= {1'b0, divInt, modOn, 1'b0, stopIdle, outEn, runSleep, 1'b0,
                          divSwitch, reqActive, 4'h0, srcSel}; // R15 R17
          end
          `RCG_ADDR_REF_TRIM: begin
            regRdData <= {divFrac, 23'h000000}; // R17
          end
          default: begin
            regRdData <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // Output pin, driven low-enabled while output enable and module enable are both set.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      refClkOutPin  <= 1'b0;
      refClkOutEn_n <= 1'b1;
    end else begin
      // Gating with the module enable keeps a stale high clock off a released pin.
      refClkOutPin  <= outEn & modOn & outClk; // R10
      refClkOutEn_n <= ~(outEn & modOn); // R10
    end
  end

endmodule // rcg_reference_clock

// File: core/rcg_map.vh
// Register map, field positions, reset values and encodings of the reference clock generator.
// Assumes a plain register port with 32-bit data and one clock domain.
// Overview of operation
// R1: usb_frc_select high picks fast RC as USB clock, else primary osc or USB PLL.
// R2: sec_osc_enable turns the secondary oscillator on when 1, off when 0.
// R3: Writing osc_switch_go starts a switch to new_osc_select; reads 0 when done.
// R4: frc_tune is a signed 6-bit offset on the fast RC frequency.
// R5: ref_source_select picks one of nine sources; codes 1001 to 1111 reserved.
// R6: ref_divider_int is 15 bits held in reference control bits 30 to 16.
// R7: ref_divider_frac in trim bits 31 to 23 adds N/512 to the divider.
// R8: Module enable bit turns the reference generator on or off.
// R9: stop_in_idle halts the module while the device is in Idle.
// R10: ref_out_enable drives the reference clock onto ref_clk_out_pin.
// R11: ref_run_in_sleep keeps output running in Sleep; ignored for sources 0000, 0001.
// R12: div_switch_go reads 1 during a divider switch, cleared by hardware when done.
// R13: While enabled, new ref_divider_int waits for div_switch_go.
// R14: While enabled, trim register writes wait for div_switch_go.
// R15: Read-only status shows 1 while a reference clock request is active.
// R16: Software should not change source or divider while request is active.
// R17: Unimplemented bits of tuning, control and trim registers read zero.
// R18: Output is source over twice (int plus frac/512); int zero passes source.
// R19: Divider switch applies on an output clock boundary, then clears div_switch_go.
// R20: new_osc_select encodes eight oscillator choices, 000 to 111.
`ifndef RCG_MAP_VH
`define RCG_MAP_VH
`define RCG_ADDR_OSC_CTRL   4'h0
`define RCG_ADDR_FRC_TUNE   4'h4
`define RCG_ADDR_REF_CTRL   4'h8
`define RCG_ADDR_REF_TRIM   4'hC
`define RCG_OSC_SWITCH_BIT  0
`define RCG_SOSC_EN_BIT     1
`define RCG_USB_FRC_BIT     2
`define RCG_NOSC_LSB        8
`define RCG_NOSC_MSB        10
`define RCG_TUNE_MSB        5
`define RCG_ACTIVE_BIT      8
`define RCG_DIVSW_BIT       9
`define RCG_SLEEP_BIT       11
`define RCG_OUT_EN_BIT      12
`define RCG_IDLE_BIT        13
`define RCG_ON_BIT          15
`define RCG_SEL_MSB         3
`define RCG_DIV_LSB         16
`define RCG_DIV_MSB         30
`define RCG_FRAC_LSB        23
`define RCG_FRAC_MSB        31
`define RCG_SEL_SYSTEM_CLOCK      4'h0
`define RCG_SEL_PERIPH_BUS_CLOCK       4'h1
`define RCG_SEL_EXTIN       4'h8
`define RCG_NOSC_RESET      3'h0
`define RCG_OSC_SWITCH_CYC  4'h8
`endif

// File: verification/rcg_reference_clock_props.sv
// Concurrent checks on the reference clock generator ports.
// Assumes one clock domain and an asynchronous active-high reset.
module rcg_reference_clock_props (
  // Clock and reset
  input logic        clk,
  input logic        sys_rst,
  // Register port
  input logic [3:0]  regAddr,
  input logic [31:0] regWrData,
  input logic        regWrite,
  input logic        regRead,
  input logic [31:0] regRdData,
  // Controls and pin
  input logic        usbFrcSelect,
  input logic        secOscEnable,
  input logic        oscSwitchReq,
  input logic [2:0]  newOscSelect,
  input logic [5:0]  frcTune,
  input logic        refClkOutPin,
  input logic        refClkOutEn_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_osc_bits: assert property (regWrite && regAddr == 4'h0
    |=> {usbFrcSelect, secOscEnable} == $past(regWrData[2:1])) else $error("osc bits");
  a_nosc_field: assert property (regWrite && regAddr == 4'h0
    |=> newOscSelect == $past(regWrData[10:8])) else $error("nosc field");
  a_switch_set: assert property (regWrite && regAddr == 4'h0 && regWrData[0]
    |=> oscSwitchReq) else $error("switch not started");
  a_switch_end: assert property ($rose(oscSwitchReq) |-> ##[1:9] !oscSwitchReq)
    else $error("switch never ends");
  a_tune_field: assert property (regWrite && regAddr == 4'h4
    |=> frcTune == $past(regWrData[5:0])) else $error("tune field");
  a_tune_unused: assert property ($past(regRead) && $past(regAddr) == 4'h4
    |-> regRdData[31:6] == 26'h0) else $error("tune unused bits");
  a_trim_unused: assert property ($past(regRead) && $past(regAddr) == 4'hC
    |-> regRdData[22:0] == 23'h0) else $error("trim unused bits");
  a_ctrl_unused: assert property ($past(regRead) && $past(regAddr) == 4'h8
    |-> {regRdData[31], regRdData[14], regRdData[10], regRdData[7:4]} == 7'h0)
    else $error("ctrl unused bits");
  a_pin_released: assert property (refClkOutEn_n |-> !refClkOutPin)
    else $error("pin driven while released");
  a_off_release: assert property (regWrite && regAddr == 4'h8 && !regWrData[15]
    |-> ##[1:2] refClkOutEn_n) else $error("pin kept after off");
  cover property (regWrite && regAddr == 4'h8 && regWrData[9]);
  cover property ($fell(oscSwitchReq));
  cover property ($rose(refClkOutPin));
endmodule // rcg_reference_clock_props
bind rcg_reference_clock rcg_reference_clock_props i_rcg_reference_clock_props (.clk, .sys_rst,
  .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .usbFrcSelect, .secOscEnable,
  .oscSwitchReq, .newOscSelect, .frcTune, .refClkOutPin, .refClkOutEn_n);

// File: verification/rcg_pin_load.sv
// Board load on the reference output pin, counting rising edges.
// Assumes a pull-down on the line, so a released pin reads low.
module rcg_pin_load (
  // Clock and count clear
  input  logic clk,
  input  logic clear,
  // Reference output pin
  input  logic refClkOutPin,
  input  logic refClkOutEn_n,
  // Edges seen
  output int   risingEdges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wireLevel;
  logic lastLevel = 1'b0;
  assign wireLevel = refClkOutEn_n ? 1'b0 : refClkOutPin;
  always @(posedge clk) begin
    lastLevel <= wireLevel;
    if (clear) risingEdges <= 0;
    else if (wireLevel && !lastLevel) risingEdges <= risingEdges + 1;
  end
endmodule // rcg_pin_load

// File: verification/rcg_reference_clock_bench.sv
// Self-checking bench for the reference clock generator.
// Assumes the map offsets 0x0, 0x4, 0x8 and 0xC; sources are bench-made toggling levels.
module rcg_reference_clock_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, regWrite, regRead, idleMode, sleepMode, oscSwitchDone, clr;
  logic usbFrcSelect, secOscEnable, oscSwitchReq, refClkOutPin, refClkOutEn_n;
  logic [3:0]  regAddr;
  logic [31:0] regWrData, regRdData, rd, w;
  logic [8:0]  src;
  logic [2:0]  newOscSelect;
  logic [5:0]  frcTune;
  int errors, comparisons, cyc, edges, k;
  rcg_reference_clock i_rcg_reference_clock (.clk, .sys_rst, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .systemClock(src[0]), .periphBusClock(src[1]), .primaryOsc(src[2]),
    .fastRcOsc(src[3]), .lowPowerRcOsc(src[4]), .secOsc(src[5]), .usbPll(src[6]),
    .sysPll(src[7]), .refClkInPin(src[8]), .idleMode, .sleepMode, .oscSwitchDone,
    .usbFrcSelect, .secOscEnable, .oscSwitchReq, .newOscSelect, .frcTune, .refClkOutPin,
    .refClkOutEn_n);
  rcg_pin_load i_rcg_pin_load (.clk, .clear(clr), .refClkOutPin, .refClkOutEn_n,
    .risingEdges(edges));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Source j has a period of 2*(j+2) cycles, so each of the nine source codes gives its own rate.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int j = 0; j < 9; j++) if (cyc % (j + 2) == 0) src[j] <= ~src[j];
    if (cyc > 60000) begin
      errors++;
      close_out();
    end
  end
  function automatic int expEdges(int s, int d, int f);
    if (s > 8) return 0;
    if (d == 0) return 640 / (2 * (s + 2));
    return 640 * 512 / (4 * (s + 2) * (d * 512 + f));
  endfunction
  task automatic check(input logic ok, input string s);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 rd = regRdData;
    @(posedge clk);
    check((rd & m) === e, "read back");
  endtask
  // Edge counts carry one edge of slack for the phase at which the window opens.
  task automatic measure(input int e);
    repeat (30) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (640) @(posedge clk);
    check((e == 0) ? edges == 0 : (edges >= e - 1 && edges <= e + 1), "edge count");
  endtask
  task automatic run(input int s, d, f, input logic [31:0] fl, input logic st);
    w = fl | (d << 16) | s | 32'h8000_C4F0;
    wr(4'h8, w & 32'hFFFF_7FFF);
    wr(4'hC, f << 23);
    wr(4'h8, w);
    rdchk(4'h8, 32'hFFFF_FCFF, w & 32'h7FFF_B80F);
    rdchk(4'h8, 32'h0000_0100, {23'h0, !st, 8'h0});
    measure((st || !fl[12]) ? 0 : expEdges(s, d, f));
  endtask
  task automatic close_out;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {sys_rst, regWrite, regRead, idleMode, sleepMode, oscSwitchDone, clr} = 7'h40;
    {regAddr, regWrData, src, cyc, errors, comparisons} = '0;
    k = $urandom(32'hCC3D5969);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 5; k++) rdchk((k == 4) ? 4'h2 : 4'(k * 4), 32'hFFFF_FFFF, 32'h0);
    wr(4'h2, 32'hFFFF_FFFF);
    for (k = 0; k < 8; k++) begin
      w = ($urandom & 32'h0000_0006) | (k << 8);
      wr(4'h0, w);
      check({newOscSelect, usbFrcSelect, secOscEnable} === {w[10:8], w[2:1]}, "osc");
      w = (k == 0) ? 32'hFFFF_FFE0 : (k == 1) ? 32'h0000_001F : $urandom;
      wr(4'h4, w);
      check(frcTune === w[5:0], "tune");
      rdchk(4'h4, 32'hFFFF_FFFF, w & 32'h0000_003F);
      wr(4'hC, w);
      rdchk(4'hC, 32'hFFFF_FFFF, w & 32'hFF80_0000);
    end
    wr(4'h0, 32'h0000_0001);
    check(oscSwitchReq === 1'b1, "switch start");
    oscSwitchDone <= 1'b1;
    @(posedge clk);
    oscSwitchDone <= 1'b0;
    rdchk(4'h0, 32'h0000_0001, 32'h0);
    for (k = 0; k < 10; k++) run(k, 0, 0, 32'h1000, 1'b0);
    run(0, 2, 0, 32'h1000, 1'b0);
    run(0, 1, 256, 32'h1000, 1'b0);
    run(3, 0, 0, 32'h0000, 1'b0);
    idleMode <= 1'b1;
    run(3, 0, 0, 32'h3000, 1'b1);
    run(3, 0, 0, 32'h1000, 1'b0);
    idleMode <= 1'b0;
    sleepMode <= 1'b1;
    run(3, 0, 0, 32'h1000, 1'b1);
    run(3, 0, 0, 32'h1800, 1'b0);
    run(0, 0, 0, 32'h1800, 1'b1);
    sleepMode <= 1'b0;
    run(0, 8, 0, 32'h1000, 1'b0);
    wr(4'h8, 32'h9000 | (2 << 16));
    wr(4'hC, 32'h8000_0000);
    measure(expEdges(0, 8, 0));
    wr(4'h8, 32'h9200 | (2 << 16));
    rdchk(4'h8, 32'h0000_0200, 32'h0000_0200);
    repeat (70) @(posedge clk);
    rdchk(4'h8, 32'h0000_0200, 32'h0);
    measure(expEdges(0, 2, 256));
    close_out();
  end
endmodule // rcg_reference_clock_bench
